// ### verilog/des_dsi_elastic_top.sv
// Interface elastic stores, slot timing, system clock and register file
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module des_dsi_elastic_top
  import des_pkg::*;
#(
  parameter int FRAME_CYCLES = DES_FRAME_CYC_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic dsi_bclk,
  input wire logic frame_sync_first,
  input wire logic frame_sync_second,
  input wire logic interface_transmit_data,
  output logic interface_receive_data,
  output logic d_enable_pin,
  input wire logic line_frame_tick,
  input wire logic line_rx_valid,
  input wire logic [DES_WORD_W-1:0] line_rx_word,
  input wire logic line_tx_req,
  output logic line_tx_valid,
  output logic [DES_WORD_W-1:0] line_tx_word
);
  localparam logic [DES_ACC_W-1:0] FRAME_CYC_W = DES_ACC_W'(FRAME_CYCLES);
  localparam logic [DES_ACC_W-1:0] HALVES_W = DES_ACC_W'(DES_SCLK_HALVES);

  // Swaps B1 and B2 when exchange is on
  function automatic logic [DES_WORD_W-1:0] xchg(input logic [DES_WORD_W-1:0] w,
                                                 input logic en);
    xchg = en ? {w[DES_B2_LSB +: DES_B_W], w[DES_B1_LSB +: DES_B_W], w[DES_D_W-1:0]} : w;
  endfunction

  // Bit index of the current clock edge; frame sync marks bit zero
  function automatic logic [DES_CNT_W-1:0] next_idx(input logic fs,
                                                    input logic [DES_CNT_W-1:0] c);
    if (fs) begin
      next_idx = '0;
    end else if (c == DES_CNT_MAX) begin
      next_idx = c;
    end else begin
      next_idx = DES_CNT_W'(c + 9'h1);
    end
  endfunction

  // True while the index lies in the word window of the slot
  function automatic logic in_win(input logic [DES_CNT_W-1:0] idx,
                                  input logic [DES_SLOT_W-1:0] slot);
    logic [DES_CNT_W:0] start;
    start = {1'b0, slot, 3'h0};
    in_win = ({1'b0, idx} >= start) && ({1'b0, idx} < (start + 10'(DES_WORD_W)));
  endfunction

  des_store_if rx_if ();
  des_store_if tx_if ();

  des_elastic_store u_rx_store (
    .pclk(pclk),
    .presetn(presetn),
    .sif(rx_if.store)
  );
  des_elastic_store u_tx_store (
    .pclk(pclk),
    .presetn(presetn),
    .sif(tx_if.store)
  );

  // Registers
  logic [1:0] ctrl;
  logic [DES_SLOT_W-1:0] rx_slot;
  logic [DES_SLOT_W-1:0] tx_slot;
  logic [1:0] stat;
  logic [1:0] mask;
  logic mode;
  logic exch;
  assign mode = ctrl[DES_CTRL_MODE_BIT];
  assign exch = ctrl[DES_CTRL_XCHG_BIT];

  // Pin synchronisers; stage 0 feeds stage 1 only
  logic [2:0] bclk_s;
  logic [1:0] fsa_s;
  logic [1:0] fsb_s;
  logic [1:0] txd_s;
  logic bclk_rise;
  logic bclk_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_s <= '0;
      fsa_s <= '0;
      fsb_s <= '0;
      txd_s <= '0;
    end else begin
      bclk_s <= {bclk_s[1:0], dsi_bclk};
      fsa_s <= {fsa_s[0], frame_sync_first};
      fsb_s <= {fsb_s[0], frame_sync_second};
      txd_s <= {txd_s[0], interface_transmit_data};
    end
  end
  assign bclk_rise = bclk_s[1] & ~bclk_s[2];
  assign bclk_fall = ~bclk_s[1] & bclk_s[2];

  // Receive direction: store to interface, timed by first frame sync
  logic [DES_CNT_W-1:0] rx_cnt;
  logic [DES_WORD_W-1:0] rx_sh;
  logic [4:0] rx_left;
  logic rx_load;
  logic rx_frame;

  assign rx_frame = bclk_rise & fsa_s[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= DES_CNT_MAX;
    end else if (bclk_rise) begin
      rx_cnt <= next_idx(fsa_s[1], rx_cnt);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_load <= 1'b0;
    end else begin
      rx_load <= rx_if.rd_req;
    end
  end

  assign rx_if.rd_req = rx_frame & (rx_left == '0);
  assign rx_if.wr_valid = line_rx_valid;
  assign rx_if.wr_word = line_rx_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh <= '0;
      rx_left <= '0;
      interface_receive_data <= 1'b0;
    end else if (rx_load) begin
      rx_sh <= xchg(rx_if.rd_word, exch);
      rx_left <= DES_WORD_BITS;
    end else if (bclk_fall && rx_left != '0 && in_win(rx_cnt, rx_slot)) begin
      interface_receive_data <= rx_sh[DES_WORD_W-1];
      rx_sh <= {rx_sh[DES_WORD_W-2:0], 1'b0};
      rx_left <= 5'(rx_left - 5'h1);
    end else if (bclk_fall) begin
      interface_receive_data <= 1'b0;
    end
  end

  // Transmit direction: interface to store, timed by second frame sync
  logic [DES_CNT_W-1:0] tx_cnt;
  logic [DES_CNT_W-1:0] tx_idx;
  logic [DES_WORD_W-1:0] tx_sh;
  logic [4:0] tx_got;
  logic tx_wr;

  assign tx_idx = next_idx(fsb_s[1], tx_cnt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= DES_CNT_MAX;
    end else if (bclk_rise) begin
      tx_cnt <= tx_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh <= '0;
      tx_got <= '0;
      tx_wr <= 1'b0;
    end else begin
      tx_wr <= 1'b0;
      if (bclk_rise && in_win(tx_idx, tx_slot)) begin
        tx_sh <= {tx_sh[DES_WORD_W-2:0], txd_s[1]};
        if (tx_got == 5'(DES_WORD_BITS - 5'h1)) begin
          tx_got <= '0;
          tx_wr <= 1'b1;
        end else begin
          tx_got <= 5'(tx_got + 5'h1);
        end
      end else if (bclk_rise && fsb_s[1]) begin
        tx_got <= '0;
      end
    end
  end

  assign tx_if.wr_valid = tx_wr;
  assign tx_if.wr_word = xchg(tx_sh, exch);
  assign tx_if.rd_req = line_tx_req;
  assign line_tx_word = tx_if.rd_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_valid <= 1'b0;
    end else begin
      line_tx_valid <= line_tx_req;
    end
  end

  // System clock locked to the line frame by fractional division
  logic [DES_ACC_W-1:0] acc;
  logic [DES_ACC_W-1:0] acc_sum;
  logic sclk;
  assign acc_sum = DES_ACC_W'(acc + HALVES_W);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
      sclk <= 1'b0;
    end else if (line_frame_tick) begin
      acc <= '0;
      sclk <= 1'b1;
    end else if (acc_sum >= FRAME_CYC_W) begin
      acc <= DES_ACC_W'(acc_sum - FRAME_CYC_W);
      sclk <= ~sclk;
    end else begin
      acc <= acc_sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_enable_pin <= 1'b0;
    end else begin
      d_enable_pin <= mode & sclk;
    end
  end

  // APB slave, zero wait states
  logic wr_en;
  logic rd_setup;
  logic mapped;

  assign mapped = (paddr == DES_CTRL_OFS) || (paddr == DES_SLOT_OFS) ||
                  (paddr == DES_STAT_OFS) || (paddr == DES_MASK_OFS) ||
                  (paddr == DES_LEVEL_OFS);
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= DES_CTRL_RST;
      rx_slot <= DES_SLOT_RST;
      tx_slot <= DES_SLOT_RST;
      mask <= DES_MASK_RST;
    end else if (wr_en) begin
      if (paddr == DES_CTRL_OFS) begin
        ctrl <= pwdata[1:0];
      end
      if (paddr == DES_SLOT_OFS) begin
        rx_slot <= pwdata[DES_SLOT_RX_LSB +: DES_SLOT_W];
        tx_slot <= pwdata[DES_SLOT_TX_LSB +: DES_SLOT_W];
      end
      if (paddr == DES_MASK_OFS) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // Sticky slip flags; a new slip beats a same-cycle clear
  logic [1:0] slip_set;
  logic [1:0] slip_clr;
  assign slip_set = {rx_if.slip, tx_if.slip};
  assign slip_clr = (wr_en && paddr == DES_STAT_OFS) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~slip_clr) | slip_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat & ~slip_clr) | slip_set) & mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        DES_CTRL_OFS: prdata <= {30'h0, ctrl};
        DES_SLOT_OFS: prdata <= {18'h0, tx_slot, 2'h0, rx_slot};
        DES_STAT_OFS: prdata <= {30'h0, stat};
        DES_MASK_OFS: prdata <= {30'h0, mask};
        DES_LEVEL_OFS: prdata <= {21'h0, tx_if.level, 5'h0, rx_if.level};
        default: prdata <= '0;
      endcase
    end
  end
endmodule

// ### inc/des_pkg.sv
// Shared constants for the interface elastic store block
package des_pkg;
  // Register byte offsets
  localparam logic [7:0] DES_CTRL_OFS = 8'h00;
  localparam logic [7:0] DES_SLOT_OFS = 8'h04;
  localparam logic [7:0] DES_STAT_OFS = 8'h08;
  localparam logic [7:0] DES_MASK_OFS = 8'h0c;
  localparam logic [7:0] DES_LEVEL_OFS = 8'h10;
  // Field positions
  localparam int DES_CTRL_MODE_BIT = 0;
  localparam int DES_CTRL_XCHG_BIT = 1;
  localparam int DES_SLOT_RX_LSB = 0;
  localparam int DES_SLOT_TX_LSB = 8;
  localparam int DES_SLOT_W = 6;
  localparam int DES_STAT_TX_SLIP_BIT = 0;
  localparam int DES_STAT_RX_SLIP_BIT = 1;
  localparam int DES_LEVEL_RX_LSB = 0;
  localparam int DES_LEVEL_TX_LSB = 8;
  // Reset values
  localparam logic [1:0] DES_CTRL_RST = 2'h1;
  localparam logic [DES_SLOT_W-1:0] DES_SLOT_RST = 6'h00;
  localparam logic [1:0] DES_MASK_RST = 2'h0;
  // Word layout: B1 [17:10], B2 [9:2], D [1:0]
  localparam int DES_WORD_W = 18;
  localparam int DES_B1_LSB = 10;
  localparam int DES_B2_LSB = 2;
  localparam int DES_B_W = 8;
  localparam int DES_D_W = 2;
  // Store geometry: four frames, half apart at reset
  localparam int DES_PTR_W = 3;
  localparam int DES_IDX_W = 2;
  localparam int DES_DEPTH = 4;
  localparam logic [DES_PTR_W-1:0] DES_WR_PTR_RST = 3'h2;
  localparam logic [DES_PTR_W-1:0] DES_RD_PTR_RST = 3'h0;
  localparam logic [DES_PTR_W-1:0] DES_FULL_LEVEL = 3'h4;
  // Interface bit counter
  localparam int DES_CNT_W = 9;
  localparam logic [DES_CNT_W-1:0] DES_CNT_MAX = 9'h1ff;
  localparam logic [4:0] DES_WORD_BITS = 5'h12;
  // Timing
  localparam int DES_CLK_PERIOD_NS = 4;
  localparam int DES_LINE_FRAME_US = 125;
  localparam int DES_SCLK_KHZ = 2048;
  localparam int DES_FRAME_CYC_DEFAULT = DES_LINE_FRAME_US * 1000 / DES_CLK_PERIOD_NS;
  localparam int DES_SCLK_HALVES = 2 * DES_SCLK_KHZ * DES_LINE_FRAME_US / 1000;
  localparam int DES_ACC_W = 16;
endpackage

// ### inc/des_store_if.sv
// Signals between the main block and one elastic store
`timescale 1ns/10ps
interface des_store_if;
  import des_pkg::*;
  logic wr_valid;
  logic [DES_WORD_W-1:0] wr_word;
  logic rd_req;
  logic [DES_WORD_W-1:0] rd_word;
  logic slip;
  logic [DES_PTR_W-1:0] level;
  modport owner (output wr_valid, output wr_word, output rd_req,
                 input rd_word, input slip, input level);
  modport store (input wr_valid, input wr_word, input rd_req,
                 output rd_word, output slip, output level);
endinterface

// ### verilog/des_elastic_store.sv
// Four-frame elastic store with whole-frame slip
`timescale 1ns/10ps
module des_elastic_store
  import des_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  des_store_if.store sif
);
  logic [DES_WORD_W-1:0] mem [DES_DEPTH];
  logic [DES_PTR_W-1:0] wr_ptr;
  logic [DES_PTR_W-1:0] rd_ptr;
  logic [DES_PTR_W-1:0] occ;
  logic full;
  logic empty;

  assign occ = DES_PTR_W'(wr_ptr - rd_ptr);
  assign full = (occ == DES_FULL_LEVEL);
  assign empty = (occ == '0);
  assign sif.level = occ;

  // Write side; a frame arriving into a full store with no read in the same cycle is dropped whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= DES_WR_PTR_RST;
    end else if (sif.wr_valid && (!full || sif.rd_req)) begin
      wr_ptr <= DES_PTR_W'(wr_ptr + 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DES_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (sif.wr_valid && (!full || sif.rd_req)) begin
      mem[wr_ptr[DES_IDX_W-1:0]] <= sif.wr_word;
    end
  end

  // Read side; an empty store with no word arriving in the same cycle repeats the last whole frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= DES_RD_PTR_RST;
      sif.rd_word <= '0;
    end else if (sif.rd_req) begin
      if (empty && !sif.wr_valid) begin
        sif.rd_word <= mem[DES_IDX_W'(rd_ptr - 3'h1)];
      end else begin
        // Empty store with a word arriving passes that word straight on
        sif.rd_word <= empty ? sif.wr_word : mem[rd_ptr[DES_IDX_W-1:0]];
        rd_ptr <= DES_PTR_W'(rd_ptr + 3'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.slip <= 1'b0;
    end else begin
      sif.slip <= (sif.rd_req && empty && !sif.wr_valid) ||
                  (sif.wr_valid && full && !sif.rd_req);
    end
  end
endmodule

// ### testbench/des_far_end.sv
// Far-end slot master: bit clock, frame syncs and slot data
`timescale 1ns/10ps
module des_far_end
  import des_pkg::*;
#(
  parameter int BITS = 64,
  parameter int TX_BIT = 8,
  parameter int RX_BIT = 16
) (
  output logic bclk,
  output logic fs_rx,
  output logic fs_tx,
  output logic sdo,
  input wire logic sdi,
  input wire logic run,
  input wire logic [DES_WORD_W-1:0] tx_word,
  output logic [DES_WORD_W-1:0] rx_word,
  output logic frame_end
);
  int idx = BITS - 1;
  int nx;
  initial begin
    bclk = 1'b0;
    {fs_rx, fs_tx, sdo, frame_end} = 4'h0;
    rx_word = '0;
  end
  always #40 bclk = ~bclk; // Single shared bit clock, bench rate
  always @(negedge bclk) begin
    nx = run ? (idx + 1) % BITS : BITS - 1;
    idx <= nx;
    fs_rx <= run && nx == 0; // Slot timing starts on the strobe
    fs_tx <= run && nx == 0; // Slot timing starts on the strobe
    frame_end <= nx == 40;
    if (nx >= TX_BIT && nx < TX_BIT + DES_WORD_W)
      sdo <= tx_word[TX_BIT + DES_WORD_W - 1 - nx];
    else
      sdo <= ~sdo;
  end
  always @(posedge bclk) begin
    if (idx > RX_BIT && idx <= RX_BIT + DES_WORD_W)
      rx_word <= {rx_word[DES_WORD_W-2:0], sdi};
  end
endmodule

// ### testbench/des_es_asserts.sv
// Port assertions for the interface elastic store block
`timescale 1ns/10ps
module des_es_asserts
  import des_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic dsi_bclk,
  input wire logic interface_receive_data,
  input wire logic line_tx_req,
  input wire logic line_tx_valid,
  input wire logic [DES_WORD_W-1:0] line_tx_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_ans;
    line_tx_req |=> line_tx_valid;
  endproperty
  a_tx_ans: assert property (p_tx_ans) else $error("no tx word"); // Store read
  property p_tx_cause;
    line_tx_valid |-> $past(line_tx_req);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("stray tx word"); // Store read
  property p_word_hold;
    !line_tx_valid |-> $stable(line_tx_word);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("tx word moved"); // Whole word
  property p_rx_edge;
    $changed(interface_receive_data) |-> !dsi_bclk;
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx bit early"); // Serial pin
  property p_irq_fall;
    $fell(irq) |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped"); // Sticky
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    psel && penable && paddr > 8'h10 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_prd_hold;
    $changed(prdata) |-> $past(psel && !penable);
  endproperty
  a_prd_hold: assert property (p_prd_hold) else $error("read data moved");
  c_tx: cover property (line_tx_valid);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule

// ### testbench/testbench.sv
// Testbench: registers, slot traffic, slips and system clock
`timescale 1ns/10ps
module testbench;
  import des_pkg::*;
  localparam int FC = 1024;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic tick = 1'b0;
  logic rx_v = 1'b0;
  logic tx_req = 1'b0;
  logic run = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, irq, bclk, fs_rx, fs_tx, sdo, rdat, denb, tx_v, fe, lerr, dp;
  logic [DES_WORD_W-1:0] rx_w = '0;
  logic [DES_WORD_W-1:0] far_tx, far_rx, tx_w;
  int err_total = 0;
  int checked = 0;
  int tcnt = 0;
  int cnt;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    tcnt <= (tcnt + 1) % FC;
    tick <= tcnt == FC - 1;
  end
  des_dsi_elastic_top #(.FRAME_CYCLES(FC)) des_dsi_elastic_top_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .dsi_bclk(bclk), .frame_sync_first(fs_rx),
    .frame_sync_second(fs_tx), .interface_transmit_data(sdo),
    .interface_receive_data(rdat), .d_enable_pin(denb), .line_frame_tick(tick),
    .line_rx_valid(rx_v), .line_rx_word(rx_w), .line_tx_req(tx_req),
    .line_tx_valid(tx_v), .line_tx_word(tx_w)
  );
  des_far_end des_far_end_inst (
    .bclk(bclk), .fs_rx(fs_rx), .fs_tx(fs_tx), .sdo(sdo), .sdi(rdat), .run(run),
    .tx_word(far_tx), .rx_word(far_rx), .frame_end(fe)
  );
  function automatic logic [DES_WORD_W-1:0] ex(input int n, input bit t, input bit x);
    logic [DES_WORD_W-1:0] w;
    w = 18'h2c5a7 ^ (18'(n) * 18'h00b3d) ^ (t ? 18'h15f00 : 18'h00000);
    ex = x ? {w[DES_B2_LSB +: DES_B_W], w[DES_B1_LSB +: DES_B_W], w[DES_D_W-1:0]} : w;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask
  task automatic line_op(input int n);
    @(posedge pclk);
    rx_v <= 1'b1;
    rx_w <= ex(n, 1'b0, 1'b0);
    tx_req <= 1'b1;
    @(posedge pclk);
    rx_v <= 1'b0;
    tx_req <= 1'b0;
    @(negedge pclk);
    chk("tx_valid", tx_v, 1'b1); // One cycle answer
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    far_tx = ex(0, 1'b1, 1'b0);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", DES_CTRL_OFS, 32'h1); // Slave mode
    rchk("slot", DES_SLOT_OFS, 32'h0);
    rchk("mask", DES_MASK_OFS, 32'h0);
    rchk("hole", 8'h40, 32'h0);
    chk("pslverr", lerr, 1'b1);
    apb(1'b1, DES_SLOT_OFS, 32'h102); // Own slot per direction
    apb(1'b1, DES_MASK_OFS, 32'h3);
    run <= 1'b1;
    for (int n = 0; n < 19; n++) begin
      @(posedge fe);
      if (n == 6 || n == 12) apb(1'b1, DES_CTRL_OFS, n == 6 ? 32'h3 : 32'h1);
      if (n < 14 || n > 16) line_op(n);
      if (n == 17) line_op(n);
      far_tx <= ex(n + 1, 1'b1, 1'b0);
      if (n >= 3 && n < 6 || n >= 9 && n < 12) begin
        chk("rx", far_rx, ex(n - 2, 1'b0, n >= 9)); // Store delay
        chk("tx", tx_w, ex(n - 2, 1'b1, n >= 9)); // Store delay
      end
      rchk("level", DES_LEVEL_OFS,
           n == 14 ? 32'h301 : n == 15 || n == 16 ? 32'h400 : 32'h202);
      if (n == 15 || n == 16) chk("rx_repeat", far_rx, ex(13, 1'b0, 1'b0)); // Repeat
      if (n >= 14 && n <= 16) begin
        rchk("stat", DES_STAT_OFS, n == 16 ? 32'h3 : 32'h0); // Slip flags
        chk("irq", irq, n == 16); // Unmasked slip
      end
      if (n == 18) begin
        apb(1'b1, DES_MASK_OFS, 32'h1);
        apb(1'b1, DES_STAT_OFS, 32'h1);
        rchk("stat", DES_STAT_OFS, 32'h2); // One flag cleared
        chk("irq", irq, 1'b0); // Masked flag
        apb(1'b1, DES_STAT_OFS, 32'h2);
        rchk("stat", DES_STAT_OFS, 32'h0); // All clear
      end
    end
    apb(1'b1, DES_CTRL_OFS, 32'h0);
    // Output register still holds the old mode for one edge
    @(posedge pclk);
    cnt = 0;
    repeat (FC) begin
      @(negedge pclk);
      cnt += int'(denb !== 1'b0);
    end
    chk("denb_off", cnt, 0); // Clock only in slave mode
    apb(1'b1, DES_CTRL_OFS, 32'h1);
    repeat (FC) @(posedge pclk);
    cnt = 0;
    dp = denb;
    repeat (FC) begin
      @(negedge pclk);
      cnt += int'(denb && !dp);
      dp = denb;
    end
    chk("denb_rate", cnt >= 255 && cnt <= 257, 1'b1); // Line-locked rate
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    complete_run();
  end
endmodule
bind des_dsi_elastic_top des_es_asserts des_es_asserts_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .dsi_bclk(dsi_bclk), .interface_receive_data(interface_receive_data),
  .line_tx_req(line_tx_req), .line_tx_valid(line_tx_valid), .line_tx_word(line_tx_word)
);
